// [hia_pkg.sv]
`timescale 1ns/1ps
// ************************************************************
// Shared constants
// ************************************************************
package hia_pkg;
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned REQ_MIN_NS = 2000000;
   localparam int unsigned REQ_CYC = (REQ_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned EE_HALF_NS = 500;
   localparam int unsigned EE_HALF_CYC = (EE_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ID_BITS = 48;
   localparam logic [4:0] CMD_CFG = 5'h00;
   localparam logic [4:0] CMD_DEVID = 5'h02;
   localparam logic [4:0] CMD_READ = 5'h04;
   localparam logic [4:0] CMD_REQ = 5'h08;
   localparam logic [4:0] CMD_SET = 5'h0C;
   localparam logic [4:0] CMD_REARB = 5'h10;
   localparam logic [4:0] CMD_ASSIGN = 5'h14;
   localparam logic [4:0] CMD_WRITE = 5'h18;
   localparam logic [4:0] CMD_CLR = 5'h1C;
   localparam logic [4:0] BCAST_HUB = 5'h1F;
   localparam logic [2:0] BCAST_CHIP = 3'h7;
   localparam logic [11:0] ADDR_ASSIGN = 12'h188;
   localparam logic [11:0] ADDR_ID = 12'h190;
   localparam logic [11:0] ADDR_REV = 12'h0AD;
   localparam logic [6:0] LEN_REQ = 7'h02;
   localparam logic [6:0] LEN_REV = 7'h01;
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_STAT = 8'h04;
   localparam logic [7:0] WB_ID_LO = 8'h08;
   localparam logic [7:0] WB_ID_HI = 8'h0C;
   localparam logic [7:0] WB_REV = 8'h10;
   localparam int unsigned CTRL_REARB = 0;
   localparam int unsigned STAT_VALID = 8;
   localparam int unsigned STAT_GRANT = 9;
   localparam int unsigned STAT_IDRDY = 10;
   localparam int unsigned STAT_CHAIN = 11;
   localparam int unsigned STAT_POS = 12;
   localparam int unsigned STAT_CFGP = 15;
   localparam logic GRANT_RST = 1'h1;
   localparam logic [4:0] HUB_RST = 5'h00;
   localparam logic [2:0] POS_RST = 3'h7;
   typedef enum logic [1:0] {TXK_CFG, TXK_REQ, TXK_RSP} hia_txk_t;
endpackage : hia_pkg

// ************************************************************
// Board identifier reader
// ************************************************************
module hia_ee_reader #(
   parameter int unsigned HALF = hia_pkg::EE_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic master_i,
   input wire logic ee_clk_i,
   output logic ee_clk_o,
   output logic ee_clk_oe_o,
   output logic ee_cs_o,
   output logic ee_cs_oe_o,
   input wire logic ee_data_i,
   output logic [47:0] id_o,
   output logic id_ready_o
);
   logic [$clog2(HALF+1)-1:0] div;
   logic [5:0] issued;
   logic run;
   logic clk_s1, clk_s2, clk_q;
   logic dat_s1, dat_s2;
   logic [5:0] got;

   // Master walks the clock; it reads its own clock back off the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= '0;
         issued <= 6'h00;
         run <= 1'h1;
         ee_clk_o <= 1'h0;
      end else if (run && master_i) begin
         if (div == ($clog2(HALF+1))'(HALF - 1)) begin
            div <= '0;
            ee_clk_o <= ~ee_clk_o;
            if (!ee_clk_o) begin
               issued <= issued + 6'h01;
            end else if (issued == 6'(hia_pkg::ID_BITS)) begin
               run <= 1'h0;
            end
         end else begin
            div <= div + 1'h1;
         end
      end
   end

   assign ee_cs_o = run;
   assign ee_clk_oe_o = master_i;
   assign ee_cs_oe_o = master_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_s1 <= 1'h0;
         clk_s2 <= 1'h0;
         clk_q <= 1'h0;
         dat_s1 <= 1'h0;
         dat_s2 <= 1'h0;
      end else begin
         clk_s1 <= ee_clk_i;
         clk_s2 <= clk_s1;
         clk_q <= clk_s2;
         dat_s1 <= ee_data_i;
         dat_s2 <= dat_s1;
      end
   end

   // Only first 48 bits, bit 47 first; never read again until reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         id_o <= 48'h0;
         got <= 6'h00;
      end else if (clk_s2 && !clk_q && got != 6'(hia_pkg::ID_BITS)) begin
         id_o <= {id_o[46:0], dat_s2};
         got <= got + 6'h01;
      end
   end

   assign id_ready_o = (got == 6'(hia_pkg::ID_BITS));
endmodule : hia_ee_reader

// [hia_arbiter.sv]
`timescale 1ns/1ps
// Function
// - Position 0 reads ID; others snoop it.
// - Position 0 requests every 2-3 ms.
// - Collisions resolved; arbitration beats normal traffic.
// - Reads beyond top address return zero.
// - Zero-length read gets no response.
// - Adopt identifier only on 48-bit match.
// - Stop requesting once identifier held.
// - Power cycle drops identifier, requests again.
// - Chain assign only when grant 0-in/1-out.
// - Clear-grant drives own grant output low.
// - Broadcast set-grant returns grant high.
// - Revision register shows first-in-chain bit.
// - Topology rise or high at start: message.
// - Message in both methods; once in chain.
// - Re-arbitrate drops identifier, restarts acquisition.
// - Read 48 bits once at power-up, store.
// - Only position 0 drives EEPROM lines.
// - First bit is 47, words MSB first.
// - Request uses code 08, repeated.
// - Assign uses code 14 for 0/1 device.
// - Clear 1C, set 0C, addressed device.
// - Topology message uses code 00.
module hia_arbiter #(
   parameter int unsigned REQ_PERIOD = hia_pkg::REQ_CYC,
   parameter int unsigned EE_HALF = hia_pkg::EE_HALF_CYC,
   parameter logic [15:0] REV_CODE = 16'h5A30 // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic arb_method_select_i,
   input wire logic [2:0] board_position_pins_i,
   input wire logic chain_grant_in_i,
   output logic chain_grant_out_o,
   input wire logic topology_change_input_i,
   input wire logic ee_clk_i,
   output logic ee_clk_o,
   output logic ee_clk_oe_o,
   output logic ee_cs_o,
   output logic ee_cs_oe_o,
   input wire logic ee_data_i,
   input wire logic rx_valid_i,
   input wire logic [4:0] rx_hub_i,
   input wire logic [2:0] rx_chip_i,
   input wire logic [4:0] rx_cmd_i,
   input wire logic [6:0] rx_len_i,
   input wire logic [11:0] rx_addr_i,
   input wire logic [63:0] rx_data_i,
   output logic tx_valid_o,
   output logic [4:0] tx_hub_o,
   output logic [2:0] tx_chip_o,
   output logic [4:0] tx_cmd_o,
   output logic [6:0] tx_len_o,
   output logic [11:0] tx_addr_o,
   output logic [63:0] tx_data_o,
   input wire logic tx_done_i,
   input wire logic tx_lost_i
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [2:0] pos_s1, pos;
   logic meth_s1, chain;
   logic gin_s1, gin;
   logic topo_s1, topo, topo_q;

   // Position resets to a non-zero code so no one drives the EEPROM early
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_s1 <= hia_pkg::POS_RST;
         pos <= hia_pkg::POS_RST;
         meth_s1 <= 1'h0;
         chain <= 1'h0;
         gin_s1 <= 1'h1;
         gin <= 1'h1;
         topo_s1 <= 1'h0;
         topo <= 1'h0;
         topo_q <= 1'h0;
      end else begin
         pos_s1 <= board_position_pins_i;
         pos <= pos_s1;
         meth_s1 <= arb_method_select_i;
         chain <= meth_s1;
         gin_s1 <= chain_grant_in_i;
         gin <= gin_s1;
         topo_s1 <= topology_change_input_i;
         topo <= topo_s1;
         topo_q <= topo;
      end
   end

   // ************************************************************
   // Board identifier
   // ************************************************************
   logic [47:0] ee_id;
   logic id_ready;

   hia_ee_reader #(.HALF(EE_HALF)) u_reader (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .master_i(pos == 3'h0),
      .ee_clk_i(ee_clk_i),
      .ee_clk_o(ee_clk_o),
      .ee_clk_oe_o(ee_clk_oe_o),
      .ee_cs_o(ee_cs_o),
      .ee_cs_oe_o(ee_cs_oe_o),
      .ee_data_i(ee_data_i),
      .id_o(ee_id),
      .id_ready_o(id_ready)
   );

   // ************************************************************
   // Message decode
   // ************************************************************
   logic [4:0] hub_id;
   logic hub_valid;
   logic sw_rearb;
   logic rx_bcast, rx_mine;
   logic rx_assign1, rx_assign2, rx_clr, rx_set, rx_rearb;
   logic rx_read, rx_devid, rearb;

   assign rx_bcast = rx_hub_i == hia_pkg::BCAST_HUB && rx_chip_i == hia_pkg::BCAST_CHIP;
   assign rx_mine = hub_valid && rx_hub_i == hub_id && rx_chip_i == pos;
   assign rx_assign1 = rx_valid_i && !chain && rx_bcast && id_ready
      && rx_cmd_i == hia_pkg::CMD_WRITE && rx_addr_i == hia_pkg::ADDR_ASSIGN
      && rx_data_i[63:16] == ee_id;
   assign rx_assign2 = rx_valid_i && chain && rx_bcast && !gin && chain_grant_out_o
      && rx_cmd_i == hia_pkg::CMD_ASSIGN;
   assign rx_clr = rx_valid_i && rx_mine && rx_cmd_i == hia_pkg::CMD_CLR;
   assign rx_set = rx_valid_i && (rx_mine || rx_bcast)
      && rx_cmd_i == hia_pkg::CMD_SET;
   assign rx_rearb = rx_valid_i && (rx_mine || rx_bcast) && rx_cmd_i == hia_pkg::CMD_REARB;
   assign rx_read = rx_valid_i && rx_mine && rx_cmd_i == hia_pkg::CMD_READ
      && rx_len_i != 7'h00;
   assign rx_devid = rx_valid_i && rx_mine && rx_cmd_i == hia_pkg::CMD_DEVID;
   assign rearb = rx_rearb || sw_rearb;

   // ************************************************************
   // Box identifier and chain grant
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || (rearb && !rx_assign1 && !rx_assign2)) begin
         hub_id <= hia_pkg::HUB_RST;
         hub_valid <= 1'h0;
      end else if (rx_assign1 || rx_assign2) begin
         hub_id <= rx_data_i[4:0];
         hub_valid <= 1'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rearb || rx_set) begin
         chain_grant_out_o <= hia_pkg::GRANT_RST;
      end else if (rx_clr) begin
         chain_grant_out_o <= 1'h0;
      end
   end

   // ************************************************************
   // Link-visible register space
   // ************************************************************
   logic [15:0] rev_word;
   assign rev_word = {REV_CODE[15:1], chain && pos == 3'h0};

   // Anything not listed reads as zero, including past the top
   function automatic logic [15:0] link_word(input logic [11:0] a);
      logic [15:0] w;
      w = 16'h0000;
      unique case (a)
         hia_pkg::ADDR_REV: w = rev_word;
         hia_pkg::ADDR_ID: w = ee_id[47:32];
         hia_pkg::ADDR_ID + 12'h001: w = ee_id[31:16];
         hia_pkg::ADDR_ID + 12'h002: w = ee_id[15:0];
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : link_word

   // ************************************************************
   // Request timer and pending messages
   // ************************************************************
   localparam int unsigned CW = $clog2(REQ_PERIOD + 1);
   logic [CW-1:0] req_cnt;
   logic req_active, req_pend, cfg_pend, rsp_pend;
   logic [4:0] rsp_cmd;
   logic [6:0] rsp_len;
   logic [11:0] rsp_addr;
   logic [15:0] rsp_word;
   hia_pkg::hia_txk_t tx_kind;
   logic tx_end;

   assign tx_end = tx_valid_o && (tx_done_i || tx_lost_i);
   assign req_active = !chain && pos == 3'h0 && id_ready && !hub_valid;

   always_ff @(posedge clk_i) begin
      if (rst_i || !req_active) begin
         req_cnt <= '0;
      end else if (req_cnt == '0) begin
         req_cnt <= CW'(REQ_PERIOD - 1);
      end else begin
         req_cnt <= req_cnt - 1'h1;
      end
   end

   // A lost request stays pending and goes again
   always_ff @(posedge clk_i) begin
      if (rst_i || !req_active) begin
         req_pend <= 1'h0;
      end else if (req_cnt == '0) begin
         req_pend <= 1'h1;
      end else if (tx_end && tx_done_i && tx_kind == hia_pkg::TXK_REQ) begin
         req_pend <= 1'h0;
      end
   end

   // Chain mode drops a collided notice so it goes out only once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_pend <= 1'h0;
      end else if (topo && !topo_q) begin
         cfg_pend <= 1'h1;
      end else if (tx_end && tx_kind == hia_pkg::TXK_CFG && (tx_done_i || chain)) begin
         cfg_pend <= 1'h0;
      end
   end

   // Normal answers are not retried
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_pend <= 1'h0;
         rsp_cmd <= 5'h00;
         rsp_len <= 7'h00;
         rsp_addr <= 12'h000;
         rsp_word <= 16'h0000;
      end else if (rx_read || rx_devid) begin
         rsp_pend <= 1'h1;
         rsp_cmd <= rx_cmd_i;
         rsp_len <= rx_devid ? hia_pkg::LEN_REV : rx_len_i;
         rsp_addr <= rx_devid ? hia_pkg::ADDR_REV : rx_addr_i;
         rsp_word <= rx_devid ? rev_word : link_word(rx_addr_i);
      end else if (tx_end && tx_kind == hia_pkg::TXK_RSP) begin
         rsp_pend <= 1'h0;
      end
   end

   // ************************************************************
   // Transmit selection
   // ************************************************************
   // Arbitration traffic is picked before answers; fields hold until done
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_valid_o <= 1'h0;
         tx_kind <= hia_pkg::TXK_CFG;
         tx_hub_o <= 5'h00;
         tx_chip_o <= 3'h0;
         tx_cmd_o <= 5'h00;
         tx_len_o <= 7'h00;
         tx_addr_o <= 12'h000;
         tx_data_o <= 64'h0;
      end else if (tx_end) begin
         tx_valid_o <= 1'h0;
      end else if (!tx_valid_o && cfg_pend) begin
         tx_valid_o <= 1'h1;
         tx_kind <= hia_pkg::TXK_CFG;
         tx_hub_o <= 5'h00;
         tx_chip_o <= 3'h0;
         tx_cmd_o <= hia_pkg::CMD_CFG;
         tx_len_o <= 7'h00;
         tx_addr_o <= 12'h000;
         tx_data_o <= 64'h0;
      end else if (!tx_valid_o && req_pend && req_active) begin
         tx_valid_o <= 1'h1;
         tx_kind <= hia_pkg::TXK_REQ;
         tx_hub_o <= 5'h00;
         tx_chip_o <= 3'h0;
         tx_cmd_o <= hia_pkg::CMD_REQ;
         tx_len_o <= hia_pkg::LEN_REQ;
         tx_addr_o <= hia_pkg::ADDR_ID;
         tx_data_o <= {ee_id, 16'h0000};
      end else if (!tx_valid_o && rsp_pend) begin
         tx_valid_o <= 1'h1;
         tx_kind <= hia_pkg::TXK_RSP;
         tx_hub_o <= 5'h00;
         tx_chip_o <= 3'h0;
         tx_cmd_o <= rsp_cmd;
         tx_len_o <= rsp_len;
         tx_addr_o <= rsp_addr;
         tx_data_o <= {48'h0, rsp_word};
      end
   end

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   function automatic logic [31:0] wb_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0;
      unique case (a)
         hia_pkg::WB_STAT: begin
            w[4:0] = hub_id;
            w[hia_pkg::STAT_VALID] = hub_valid;
            w[hia_pkg::STAT_GRANT] = chain_grant_out_o;
            w[hia_pkg::STAT_IDRDY] = id_ready;
            w[hia_pkg::STAT_CHAIN] = chain;
            w[hia_pkg::STAT_POS +: 3] = pos;
            w[hia_pkg::STAT_CFGP] = cfg_pend;
         end
         hia_pkg::WB_ID_LO: w = ee_id[31:0];
         hia_pkg::WB_ID_HI: w = {16'h0000, ee_id[47:32]};
         hia_pkg::WB_REV: w = {16'h0000, rev_word};
         default: w = 32'h0;
      endcase
      return w;
   endfunction : wb_word

   logic wb_req;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign sw_rearb = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == hia_pkg::WB_CTRL
      && wb_sel_i[0] && wb_dat_i[hia_pkg::CTRL_REARB];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? wb_word(wb_adr_i) : 32'h0;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   rearb_clear_a: assert property (rearb && !rx_assign1 && !rx_assign2 |=> !hub_valid)
      else $error("identifier kept after re-arbitrate");
   match_only_a: assert property ($rose(hub_valid) |-> $past(rx_assign1 || rx_assign2))
      else $error("identifier taken without matching assignment");
   chain_accept_a: assert property (rx_assign2 && !sw_rearb
      |=> hub_valid && hub_id == $past(rx_data_i[4:0]))
      else $error("chain assignment not taken");
   grant_clear_a: assert property (rx_clr && !rearb |=> !chain_grant_out_o)
      else $error("grant output not cleared");
   grant_reset_a: assert property ($past(rst_i) |-> chain_grant_out_o && !hub_valid)
      else $error("reset state wrong");
   req_stop_a: assert property (hub_valid && $past(hub_valid) |-> !req_pend)
      else $error("request pending while identifier held");
   req_period_a: assert property ($rose(req_pend) |-> $past(req_cnt) == '0
      && $past(req_active))
      else $error("request raised off schedule");
   ee_drive_a: assert property (pos != 3'h0 |-> !ee_clk_oe_o && !ee_cs_oe_o)
      else $error("non-zero position drives EEPROM");
   zero_read_a: assert property (rx_valid_i && rx_cmd_i == hia_pkg::CMD_READ
      && rx_len_i == 7'h00 && !rsp_pend && !rx_devid |=> !rsp_pend)
      else $error("zero-length read answered");
   cfg_seen_a: assert property (topo && !topo_q |=> cfg_pend)
      else $error("topology change not noted");
   cfg_zero_a: assert property (tx_valid_o && tx_kind == hia_pkg::TXK_CFG
      |-> tx_cmd_o == hia_pkg::CMD_CFG && tx_data_o == 64'h0 && tx_len_o == 7'h00)
      else $error("topology message not all zeros");
   arb_first_a: assert property ($rose(tx_valid_o) && $past(req_pend && req_active)
      && !$past(cfg_pend) |-> tx_cmd_o == hia_pkg::CMD_REQ)
      else $error("answer sent ahead of request");

   assigned_c: cover property ($rose(hub_valid) && !chain);
   chain_c: cover property (rx_assign2 ##[1:50] rx_clr);
   cfg_c: cover property (tx_end && tx_kind == hia_pkg::TXK_CFG);
   rsp_c: cover property (tx_end && tx_kind == hia_pkg::TXK_RSP);
endmodule : hia_arbiter

// [hia_mgr_model.sv]
`timescale 1ns/1ps
// ************************************************************
// Manager side of the link: ends every outgoing message
// ************************************************************
module hia_mgr_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_valid_i,
   input wire logic [3:0] wait_i,
   input wire logic lose_i,
   output logic tx_done_o,
   output logic tx_lost_o
);
   logic [3:0] cnt;
   logic busy;
   // Busy keeps one message from being ended twice while valid falls
   always_ff @(posedge clk_i) begin
      tx_done_o <= 1'b0;
      tx_lost_o <= 1'b0;
      if (rst_i) begin
         cnt <= 4'h0;
         busy <= 1'b0;
      end else if (tx_valid_i && !busy) begin
         if (cnt == wait_i) begin
            tx_lost_o <= lose_i;
            tx_done_o <= !lose_i;
            busy <= 1'b1;
            cnt <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end else if (!tx_valid_i) begin
         busy <= 1'b0;
      end
   end
endmodule : hia_mgr_model

// [hia_arbiter_bench.sv]
`timescale 1ns/1ps
module hia_arbiter_bench;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [47:0] ROM = 48'hA5C3_1E0F_7B29; // Arbitrary board identifier
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic chain_grant_out_o, ee_clk_o, ee_clk_oe_o, ee_cs_o, ee_cs_oe_o, ee_clk_i;
   logic arb_method_select_i = 1'b0, chain_grant_in_i = 1'b1, topology_change_input_i = 1'b0;
   logic [2:0] board_position_pins_i = 3'h0, rx_chip_i = 3'h0, tx_chip_o;
   logic ee_q = 1'b0, ee_data_i = 1'b1, rx_valid_i = 1'b0, lose = 1'b0;
   logic [4:0] rx_hub_i = 5'h00, rx_cmd_i = 5'h00, tx_hub_o, tx_cmd_o;
   logic [6:0] rx_len_i = 7'h00, tx_len_o;
   logic [11:0] rx_addr_i = 12'h000, tx_addr_o;
   logic [63:0] rx_data_i = 64'h0, tx_data_o;
   logic tx_valid_o, tx_done_i, tx_lost_i;
   logic [3:0] slow = 4'h0;
   int mismatches = 0, checked = 0, k = 0;
   hia_arbiter #(.REQ_PERIOD(50), .EE_HALF(2), .REV_CODE(16'h5A30)) uut (.*);
   hia_mgr_model mgr (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o), .wait_i(slow),
      .lose_i(lose), .tx_done_o(tx_done_i), .tx_lost_o(tx_lost_i));
   always #4 clk_i = ~clk_i;
   // Clock line idles low when nobody drives it
   assign ee_clk_i = ee_clk_oe_o ? ee_clk_o : 1'b0;
   // EEPROM streams bit 47 first and moves on at each falling clock
   always @(posedge clk_i) begin
      ee_q <= ee_clk_i;
      if (rst_i) k <= 0;
      else if (ee_q && !ee_clk_i) k <= k + 1;
      ee_data_i <= (k < 48) ? ROM[47 - k] : ~ee_data_i;
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task chk(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d = 32'h0);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task rx(input logic [4:0] h, input logic [2:0] c, input logic [4:0] m, input logic [6:0] l,
      input logic [11:0] a, input logic [63:0] d);
      rx_valid_i <= 1'b1;
      rx_hub_i <= h;
      rx_chip_i <= c;
      rx_cmd_i <= m;
      rx_len_i <= l;
      rx_addr_i <= a;
      rx_data_i <= d;
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask : rx
   task ex(input logic [4:0] m, input logic [6:0] l, input logic [11:0] a, input logic [63:0] d);
      int n;
      n = 0;
      while (tx_valid_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk({tx_valid_o, tx_hub_o, tx_chip_o, tx_cmd_o, tx_len_o, tx_addr_o}, {9'h100, m, l, a});
      chk(tx_data_o, d);
      while (tx_valid_o === 1'b1 && n < 800) begin
         @(posedge clk_i);
         n++;
      end
   endtask : ex
   task quiet(input int n);
      int h;
      h = 0;
      repeat (n) begin
         @(posedge clk_i);
         if (tx_valid_o !== 1'b0) h++;
      end
      chk(64'(h), 64'h0);
   endtask : quiet
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_boot;
      int n;
      n = 0;
      wb(1'b0, hia_pkg::WB_STAT);
      chk({q[11], q[9:8]}, 3'h2);
      wb(1'b0, 8'h20);
      chk(q, 32'h0);
      while (q[hia_pkg::STAT_IDRDY] !== 1'b1 && n < 200) begin
         wb(1'b0, hia_pkg::WB_STAT);
         n++;
      end
      chk({ee_clk_oe_o, ee_cs_oe_o, ee_cs_o}, 3'h6);
      wb(1'b0, hia_pkg::WB_ID_LO);
      chk(q, ROM[31:0]);
      wb(1'b0, hia_pkg::WB_ID_HI);
      chk(q, {16'h0, ROM[47:32]});
      $display("boot test done");
   endtask : t_boot
   task t_request;
      slow <= 4'h5;
      ex(hia_pkg::CMD_REQ, hia_pkg::LEN_REQ, hia_pkg::ADDR_ID, {ROM, 16'h0});
      lose <= 1'b1;
      ex(hia_pkg::CMD_REQ, hia_pkg::LEN_REQ, hia_pkg::ADDR_ID, {ROM, 16'h0});
      lose <= 1'b0;
      ex(hia_pkg::CMD_REQ, hia_pkg::LEN_REQ, hia_pkg::ADDR_ID, {ROM, 16'h0});
      slow <= 4'h1;
      rx(5'h1F, 3'h7, hia_pkg::CMD_WRITE, 7'h02, 12'h188, {~ROM, 16'h3});
      wb(1'b0, hia_pkg::WB_STAT);
      chk(q[8], 1'b0);
      rx(5'h1F, 3'h7, hia_pkg::CMD_WRITE, 7'h02, 12'h188, {ROM, 16'h3});
      wb(1'b0, hia_pkg::WB_STAT);
      chk({q[8], q[4:0]}, 6'h23);
      repeat (10) @(posedge clk_i);
      quiet(120);
      $display("request test done");
   endtask : t_request
   task t_link;
      rx(5'h03, 3'h0, hia_pkg::CMD_READ, 7'h00, 12'h0AD, 64'h0);
      quiet(20);
      rx(5'h03, 3'h0, hia_pkg::CMD_READ, 7'h01, 12'h1F0, 64'h0);
      ex(hia_pkg::CMD_READ, 7'h01, 12'h1F0, 64'h0);
      rx(5'h03, 3'h0, hia_pkg::CMD_DEVID, 7'h01, 12'h000, 64'h0);
      ex(hia_pkg::CMD_DEVID, hia_pkg::LEN_REV, hia_pkg::ADDR_REV, 64'h5A30);
      topology_change_input_i <= 1'b1;
      ex(hia_pkg::CMD_CFG, 7'h00, 12'h000, 64'h0);
      topology_change_input_i <= 1'b0;
      rx(5'h1F, 3'h7, hia_pkg::CMD_REARB, 7'h00, 12'h000, 64'h0);
      wb(1'b0, hia_pkg::WB_STAT);
      chk(q[8], 1'b0);
      ex(hia_pkg::CMD_REQ, hia_pkg::LEN_REQ, hia_pkg::ADDR_ID, {ROM, 16'h0});
      $display("link test done");
   endtask : t_link
   task t_chain;
      arb_method_select_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      rx(5'h1F, 3'h7, hia_pkg::CMD_ASSIGN, 7'h01, 12'h000, 64'h9);
      wb(1'b0, hia_pkg::WB_STAT);
      chk(q[8], 1'b0);
      chain_grant_in_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rx(5'h1F, 3'h7, hia_pkg::CMD_ASSIGN, 7'h01, 12'h000, 64'h9);
      wb(1'b0, hia_pkg::WB_STAT);
      chk({q[11], q[8], q[4:0]}, 7'h69);
      wb(1'b0, hia_pkg::WB_REV);
      chk(q[0], 1'b1);
      rx(5'h09, 3'h0, hia_pkg::CMD_CLR, 7'h00, 12'h000, 64'h0);
      @(posedge clk_i);
      chk(chain_grant_out_o, 1'b0);
      rx(5'h1F, 3'h7, hia_pkg::CMD_ASSIGN, 7'h01, 12'h000, 64'hA);
      wb(1'b0, hia_pkg::WB_STAT);
      chk(q[4:0], 5'h09);
      rx(5'h1F, 3'h7, hia_pkg::CMD_SET, 7'h00, 12'h000, 64'h0);
      @(posedge clk_i);
      chk(chain_grant_out_o, 1'b1);
      wb(1'b1, hia_pkg::WB_CTRL, 32'h1);
      wb(1'b0, hia_pkg::WB_STAT);
      chk({q[9:8], q[4:0]}, 7'h40);
      $display("chain test done");
   endtask : t_chain
   task tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_boot;
      t_request;
      t_link;
      t_chain;
      tally_and_finish;
   end
   // Whole run needs about a thousand cycles; this is ample margin
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      tally_and_finish;
   end
endmodule : hia_arbiter_bench
